// ---- acr_pkg.sv ----
// Package: register map, field positions and timing for the converter control block
package acr_pkg;
    // Register addresses on the special function register port
    localparam logic [7:0] ACR_ADDR_CLKDIV = 8'hf2;
    localparam logic [7:0] ACR_ADDR_CONTROL = 8'hf3;
    localparam logic [7:0] ACR_ADDR_RES_LOW = 8'hf4;
    localparam logic [7:0] ACR_ADDR_RES_HIGH = 8'hf5;
    localparam logic [7:0] ACR_ADDR_PINCFG = 8'hf6;
    // Control and prescaler register field positions
    localparam int ACR_BIT_QUIET = 6;
    localparam int ACR_BIT_ENABLE = 5;
    localparam int ACR_BIT_DONE = 4;
    localparam int ACR_BIT_START = 3;
    localparam int ACR_CH_MSB = 2;
    localparam int ACR_PRS_MSB = 4;
    // Reset values
    localparam logic [7:0] ACR_RST_BYTE = 8'h00;
    localparam logic [4:0] ACR_RST_PRS = 5'h00;
    localparam logic [2:0] ACR_RST_CH = 3'h0;
    localparam logic [9:0] ACR_RST_RESULT = 10'h000;
    // Reserved bits read as this (indeterminate in the part, fixed here)
    localparam logic [7:0] ACR_RSVD_FILL = 8'h00;
    // Divider: zero prescaler means these divide ratios in peripheral clocks
    localparam logic [7:0] ACR_DIV_ZERO_X1 = 8'h80;
    localparam logic [7:0] ACR_DIV_ZERO_X2 = 8'h40;
    localparam int ACR_MULT_X1_SHIFT = 2;
    localparam int ACR_MULT_X2_SHIFT = 1;
    // Conversion length in converter clocks: sample plus ten bits
    localparam logic [3:0] ACR_CONV_CLOCKS = 4'hb;

    typedef enum logic [1:0] {
        ACR_IDLE = 2'b00,
        ACR_RUN = 2'b01,
        ACR_DONE = 2'b11
    } acr_state_t;

    // Request towards the analog core
    typedef struct packed {
        logic enable;
        logic [2:0] channel;
        logic sample;
    } acr_core_req_t;
endpackage : acr_pkg

// ---- acr_clkdiv.sv ----
// Converter clock divider producing a one-cycle enable pulse
`timescale 1ns/1ps
module acr_clkdiv
    import acr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic run,
    input wire logic double_speed_clock_mode,
    input wire logic [4:0] clock_divider_value,
    output logic tick
);
    logic [7:0] ratio;
    logic [7:0] cnt_reg;

    // Ratio in crystal clocks; zero prescaler takes the long fixed ratio
    always_comb begin
        if (clock_divider_value == ACR_RST_PRS) begin
            ratio = double_speed_clock_mode ? ACR_DIV_ZERO_X2 : ACR_DIV_ZERO_X1;
        end else if (double_speed_clock_mode) begin
            ratio = {3'h0, clock_divider_value} << ACR_MULT_X2_SHIFT;
        end else begin
            ratio = {3'h0, clock_divider_value} << ACR_MULT_X1_SHIFT;
        end
    end

    // Counter restarts while idle so each conversion begins on a full period
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 8'h00;
        end else if (!run || cnt_reg >= ratio - 8'h01) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    assign tick = run && (cnt_reg >= ratio - 8'h01);
endmodule : acr_clkdiv

// ---- acr_seq.sv ----
// Conversion sequencer counting converter clocks and capturing the result
`timescale 1ns/1ps
module acr_seq
    import acr_pkg::*;
#(
    parameter logic [3:0] CONV_CLOCKS = ACR_CONV_CLOCKS
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic launch,
    input wire logic tick,
    input wire logic [9:0] core_result,
    output logic busy,
    output logic finish,
    output logic [9:0] result_reg
);
    acr_state_t state_reg;
    logic [3:0] clocks_reg;

    // Idle, run for the conversion length, one cycle of completion
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ACR_IDLE;
            clocks_reg <= 4'h0;
        end else begin
            case (state_reg)
                ACR_IDLE: begin
                    clocks_reg <= 4'h0;
                    if (launch) begin
                        state_reg <= ACR_RUN;
                    end
                end
                ACR_RUN: begin
                    if (tick) begin
                        clocks_reg <= clocks_reg + 4'h1;
                        if (clocks_reg == CONV_CLOCKS - 4'h1) begin
                            state_reg <= ACR_DONE;
                        end
                    end
                end
                default: begin
                    state_reg <= ACR_IDLE;
                end
            endcase
        end
    end

    // Result latched at completion so both bytes change together
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            result_reg <= ACR_RST_RESULT;
        end else if (state_reg == ACR_DONE) begin
            result_reg <= core_result;
        end
    end

    assign busy = (state_reg != ACR_IDLE);
    assign finish = (state_reg == ACR_DONE);
endmodule : acr_seq

// ---- acr_top.sv ----
// Converter control registers: pin config, control, prescaler and result bytes
//
// Notes on behaviour
// - Quiet bit halts the CPU during conversion; peripherals keep running.
// - Enable bit powers the converter; clear puts it in standby.
// - Standard mode: crystal over four times prescaler, or 128 when zero.
// - Double speed: crystal over two times prescaler, or 64 when zero.
// - Reserved prescaler and low result bits are undefined; never write ones.
// - High result byte is read-only, holding result bits 9 to 2.
// - Low result byte is read-only, holding result bits 1 to 0.
// - Reset clears all control bits: standby, idle, channel zero.
// - Reset clears pin configuration so no pin is an analog input.
// - Start on a channel whose pin bit is clear does nothing.
// - Start bit launches one conversion; hardware clears it on completion.
// - Done flag set when result ready; only software clears it.
// - Channel code 0 to 7 selects analog input 0 to 7.
`timescale 1ns/1ps
module acr_top
    import acr_pkg::*;
#(
    parameter logic [3:0] CONV_CLOCKS = ACR_CONV_CLOCKS
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic double_speed_clock_mode,
    input wire logic [9:0] core_result,
    output acr_core_req_t core_req,
    output logic [7:0] pin_as_analog_input,
    output logic cpu_hold,
    output logic conversion_done_flag,
    input wire logic converter_irq_enable,
    input wire logic global_irq_enable,
    output logic converter_irq
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic quiet_cpu_during_conversion_reg;
    logic converter_enable_reg;
    logic done_reg;
    logic start_reg;
    logic [2:0] channel_select_reg;
    logic [4:0] clock_divider_value_reg;
    logic [7:0] pin_config_reg;
    logic [7:0] sfr_rdata_reg;
    logic busy;
    logic finish;
    logic tick;
    logic launch;
    logic [9:0] result_reg;
    logic wr_ctl;

    assign wr_ctl = sfr_wr && (sfr_addr == ACR_ADDR_CONTROL);

    // A start is only acted on for an enabled converter and a configured pin
    assign launch = start_reg && !busy && converter_enable_reg
                    && pin_config_reg[channel_select_reg];

    // Control register; reset leaves standby, channel zero, nothing pending
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            quiet_cpu_during_conversion_reg <= 1'b0;
            converter_enable_reg <= 1'b0;
            channel_select_reg <= ACR_RST_CH;
        end else if (wr_ctl) begin
            quiet_cpu_during_conversion_reg <= sfr_wdata[ACR_BIT_QUIET];
            converter_enable_reg <= sfr_wdata[ACR_BIT_ENABLE];
            channel_select_reg <= sfr_wdata[ACR_CH_MSB:0];
        end
    end

    // Start bit: software sets it, completion clears it; dead starts drop
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            start_reg <= 1'b0;
        end else if (finish) begin
            start_reg <= 1'b0;
        end else if (wr_ctl) begin
            start_reg <= sfr_wdata[ACR_BIT_START];
        end else if (start_reg && !busy && !launch) begin
            start_reg <= 1'b0;
        end
    end

    // Done flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            done_reg <= 1'b0;
        end else if (finish) begin
            done_reg <= 1'b1;
        end else if (wr_ctl && !sfr_wdata[ACR_BIT_DONE]) begin
            done_reg <= 1'b0;
        end
    end

    // Prescaler and pin configuration; reserved prescaler bits not stored
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clock_divider_value_reg <= ACR_RST_PRS;
            pin_config_reg <= ACR_RST_BYTE;
        end else if (sfr_wr && sfr_addr == ACR_ADDR_CLKDIV) begin
            clock_divider_value_reg <= sfr_wdata[ACR_PRS_MSB:0];
        end else if (sfr_wr && sfr_addr == ACR_ADDR_PINCFG) begin
            pin_config_reg <= sfr_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path; result bytes ignore writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata_reg <= ACR_RST_BYTE;
        end else if (sfr_rd) begin
            if (sfr_addr == ACR_ADDR_CLKDIV) begin
                sfr_rdata_reg <= {ACR_RSVD_FILL[7:5], clock_divider_value_reg};
            end else if (sfr_addr == ACR_ADDR_CONTROL) begin
                sfr_rdata_reg <= {1'b0, quiet_cpu_during_conversion_reg, converter_enable_reg,
                                  done_reg, start_reg, channel_select_reg};
            end else if (sfr_addr == ACR_ADDR_RES_LOW) begin
                sfr_rdata_reg <= {ACR_RSVD_FILL[7:2], result_reg[1:0]};
            end else if (sfr_addr == ACR_ADDR_RES_HIGH) begin
                sfr_rdata_reg <= result_reg[9:2];
            end else if (sfr_addr == ACR_ADDR_PINCFG) begin
                sfr_rdata_reg <= pin_config_reg;
            end else begin
                sfr_rdata_reg <= ACR_RST_BYTE;
            end
        end
    end

    assign sfr_rdata = sfr_rdata_reg;
    assign sfr_hit = (sfr_addr >= ACR_ADDR_CLKDIV) && (sfr_addr <= ACR_ADDR_PINCFG);

    ////////////////////////////////////////////////////////////////////////
    // Converter clock and sequencing
    acr_clkdiv u_clkdiv (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .run(busy),
        .double_speed_clock_mode(double_speed_clock_mode),
        .clock_divider_value(clock_divider_value_reg),
        .tick(tick)
    );

    acr_seq #(
        .CONV_CLOCKS(CONV_CLOCKS)
    ) u_seq (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .launch(launch),
        .tick(tick),
        .core_result(core_result),
        .busy(busy),
        .finish(finish),
        .result_reg(result_reg)
    );

    // Analog side: standby when disabled, sample the selected input
    assign core_req = '{
        enable: converter_enable_reg,
        channel: channel_select_reg,
        sample: busy && !finish
    };
    assign pin_as_analog_input = pin_config_reg;

    // CPU halted only while a quiet-mode conversion runs; released when the sequencer enters completion, a cycle before the done flag
    assign cpu_hold = quiet_cpu_during_conversion_reg && busy && !finish;
    assign conversion_done_flag = done_reg;
    // Enables live in the interrupt controller; gated here for delivery
    assign converter_irq = done_reg && converter_irq_enable && global_irq_enable;
endmodule : acr_top

// ---- acr_top_props.sv ----
// Checker: port timing relations of the converter control block
`timescale 1ns/1ps
module acr_top_props
    import acr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire acr_core_req_t core_req,
    input wire logic [7:0] pin_as_analog_input,
    input wire logic cpu_hold,
    input wire logic conversion_done_flag,
    input wire logic converter_irq_enable,
    input wire logic global_irq_enable,
    input wire logic converter_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    chk_hold_while_run: assert property (cpu_hold |-> core_req.sample)
        else $error("cpu held with no conversion");
    chk_sample_enabled: assert property (core_req.sample |-> core_req.enable)
        else $error("conversion while in standby");
    chk_irq_gate: assert property (converter_irq == (conversion_done_flag
        && converter_irq_enable && global_irq_enable)) else $error("irq gating off");
    chk_launch_pin: assert property ($rose(core_req.sample)
        |-> pin_as_analog_input[core_req.channel]) else $error("launch on unset pin");
    chk_conv_length: assert property ($rose(core_req.sample) |=> core_req.sample[*8])
        else $error("conversion too short");
    chk_done_follows: assert property ($fell(core_req.sample) |-> ##[0:3] conversion_done_flag)
        else $error("done flag missing");
    chk_done_sticky: assert property (conversion_done_flag && !(sfr_wr
        && sfr_addr == ACR_ADDR_CONTROL && !sfr_wdata[ACR_BIT_DONE]) |=> conversion_done_flag)
        else $error("done flag lost");
    chk_pin_write: assert property (sfr_wr && sfr_addr == ACR_ADDR_PINCFG
        |=> pin_as_analog_input == $past(sfr_wdata)) else $error("pin config not taken");
    chk_prs_reserved: assert property (sfr_rd && sfr_addr == ACR_ADDR_CLKDIV
        |=> sfr_rdata[7:5] == 3'b000) else $error("reserved bits not zero");
endmodule : acr_top_props

// ---- acr_core_model.sv ----
// Partner: analog multiplexer and converter core
`timescale 1ns/1ps
module acr_core_model
    import acr_pkg::*;
(
    input wire logic clk_sys,
    input wire acr_core_req_t core_req,
    input wire logic [9:0] level,
    output logic [9:0] core_result
);
    logic flip = 1'b0;
    // Standby lines toggle so a stale capture cannot pass by luck
    always_ff @(posedge clk_sys) begin
        flip <= ~flip;
    end
    // Channel code mixed into the level picks input 0 to 7
    assign core_result = core_req.enable ? level ^ {7'h00, core_req.channel}
                                         : {10{flip}};
endmodule : acr_core_model

// ---- tb_acr_top.sv ----
// Testbench: register access, refused start and conversions on all channels
`timescale 1ns/1ps
module tb_acr_top;
    import acr_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic double_speed_clock_mode = 1'b0;
    logic converter_irq_enable = 1'b0;
    logic global_irq_enable = 1'b0;
    logic [9:0] level = 10'h000;
    logic [9:0] core_result;
    logic [7:0] sfr_rdata;
    logic [7:0] pin_as_analog_input;
    logic sfr_hit;
    logic cpu_hold;
    logic conversion_done_flag;
    logic converter_irq;
    acr_core_req_t core_req;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rng = 32'h0000ed19;
    acr_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .double_speed_clock_mode(double_speed_clock_mode), .core_result(core_result),
        .core_req(core_req), .pin_as_analog_input(pin_as_analog_input), .cpu_hold(cpu_hold),
        .conversion_done_flag(conversion_done_flag), .converter_irq(converter_irq),
        .converter_irq_enable(converter_irq_enable), .global_irq_enable(global_irq_enable));
    acr_core_model u_core (.clk_sys(clk_sys), .core_req(core_req), .level(level),
        .core_result(core_result));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Hang guard, far above the slowest divider setting
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            close_out();
        end
    end
    function automatic logic [31:0] next_rand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : next_rand
    // Converter clock period in system clocks
    function automatic int ratio(input logic [4:0] prs, input logic dbl);
        if (prs == 5'h00) return dbl ? 64 : 128;
        return dbl ? 2 * prs : 4 * prs;
    endfunction : ratio
    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        cmp_count++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask : wr
    // Read strobe for one edge; data is registered, so taken a cycle later
    task automatic rchk(input logic [7:0] a, input logic [7:0] want);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        check({2'b00, sfr_rdata}, {2'b00, want});
    endtask : rchk
    task automatic close_out();
        $display("compares %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    initial begin : main
        logic [31:0] r;
        logic [9:0] res;
        logic [4:0] prs;
        int cnt;
        int hold;
        int rt;
        repeat (20) @(negedge clk_sys);
        arst_n = 1'b1;
        // Sweep around the map: reset values and the address hit flag
        for (int a = 8'hf0; a < 8'hf8; a++) begin
            rchk(8'(a), 8'h00);
            check(10'(sfr_hit), 10'(a >= int'(ACR_ADDR_CLKDIV) && a <= int'(ACR_ADDR_PINCFG)));
        end
        wr(ACR_ADDR_RES_HIGH, 8'hff);
        wr(ACR_ADDR_RES_LOW, 8'hff);
        rchk(ACR_ADDR_RES_HIGH, 8'h00);
        rchk(ACR_ADDR_RES_LOW, 8'h00);
        wr(ACR_ADDR_CLKDIV, 8'h1f);
        rchk(ACR_ADDR_CLKDIV, 8'h1f);
        // Start with pin bit clear: start drops, nothing runs
        wr(ACR_ADDR_CONTROL, 8'h28);
        check(10'(core_req.enable), 10'h001);
        rchk(ACR_ADDR_CONTROL, 8'h20);
        check(10'(core_req.sample), 10'h000);
        wr(ACR_ADDR_CONTROL, 8'h00);
        check(10'(core_req.enable), 10'h000);
        // Every channel; zero prescaler on the first two in both clock modes
        for (int ch = 0; ch < 8; ch++) begin
            r = next_rand();
            prs = (ch < 2) ? 5'h00 : 5'(r[1:0] % 3 + 1);
            double_speed_clock_mode = ch[0];
            level = r[21:12];
            converter_irq_enable = r[4];
            global_irq_enable = r[5] | (ch == 7);
            res = r[21:12] ^ 10'(ch);
            rt = ratio(prs, ch[0]);
            wr(ACR_ADDR_CLKDIV, {3'b000, prs});
            wr(ACR_ADDR_PINCFG, 8'h01 << ch);
            wr(ACR_ADDR_CONTROL, 8'h20 | 8'(ch));
            wr(ACR_ADDR_CONTROL, 8'h68 | 8'(ch));
            cnt = 0;
            hold = 0;
            for (int w = 0; w < 2000 && conversion_done_flag !== 1'b1; w++) begin
                @(negedge clk_sys);
                cnt += int'(core_req.sample === 1'b1);
                hold += int'(cpu_hold === 1'b1);
            end
            check(10'(cnt == int'(ACR_CONV_CLOCKS) * rt), 10'h001);
            check(10'(hold > 0 && hold <= cnt + 2 && hold + 2 >= cnt), 10'h001);
            check(10'(converter_irq), 10'(converter_irq_enable & global_irq_enable));
            rchk(ACR_ADDR_RES_HIGH, res[9:2]);
            rchk(ACR_ADDR_RES_LOW, {6'h00, res[1:0]});
            rchk(ACR_ADDR_CONTROL, 8'h70 | 8'(ch));
            // Writing a one to the done bit must leave the flag standing
            wr(ACR_ADDR_CONTROL, 8'h30 | 8'(ch));
            rchk(ACR_ADDR_CONTROL, 8'h30 | 8'(ch));
            wr(ACR_ADDR_CONTROL, 8'h20 | 8'(ch));
            check(10'(conversion_done_flag), 10'h000);
        end
        close_out();
    end
endmodule : tb_acr_top
bind acr_top acr_top_props u_props (.clk_sys(clk_sys), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .core_req(core_req), .pin_as_analog_input(pin_as_analog_input), .cpu_hold(cpu_hold),
    .conversion_done_flag(conversion_done_flag), .converter_irq(converter_irq),
    .converter_irq_enable(converter_irq_enable), .global_irq_enable(global_irq_enable));
